// [dv/keypad_level_interrupt_tb.sv]
`timescale 1ns/100ps
module keypad_level_interrupt_tb;
  import kpli_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        keypad_irq, keypad_wake, event_irq;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0]  pressed, port_a_pin, keypad_pin_mode;
  int          miscompares, checks;

  always #5 pclk = ~pclk;

  kpli_keys keys_u (.pressed(pressed), .port_a_pin(port_a_pin));
  kpli_keypad dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pin(port_a_pin),
    .keypad_pin_mode(keypad_pin_mode), .keypad_irq(keypad_irq),
    .keypad_wake(keypad_wake), .event_irq(event_irq));

  task tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Opens on the edge after the call, so two calls never meet in one time step.
  // Answers are taken at the falling edge, where they stand as the next rise sees them.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 50)
      miscompares++;
    rdata = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task look;
    @(negedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task settle;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask

  task press(input logic [7:0] v);
    @(posedge pclk);
    pressed <= v;
    settle;
  endtask

  task t_reset;
    rd(KPLI_ADDR_FLAGS, 32'h0);
    rd(KPLI_ADDR_LEVEL_SELECT, 32'h0);
    rd(KPLI_ADDR_INPUT_ENABLE, 32'h0);
    rd(KPLI_ADDR_CONTROL, 32'h0);
    rd(KPLI_ADDR_INT_MASK, 32'h0);
    rd(KPLI_ADDR_INT_STATUS, 32'h0);
    wr(KPLI_ADDR_FLAGS, 32'h0);
    rd(KPLI_ADDR_FLAGS, 32'h0);
    look;
    chk({31'h0, keypad_irq}, 32'h0);
    chk({31'h0, keypad_wake}, 32'h0);
    apb(1'b0, 12'h300, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdata, 32'h0);
  endtask

  task t_low;
    press(8'h08);
    rd(KPLI_ADDR_FLAGS, 32'h08);
    look;
    chk({31'h0, keypad_irq}, 32'h0);
    chk({24'h0, keypad_pin_mode}, 32'h0);
    wr(KPLI_ADDR_INPUT_ENABLE, 32'h08);
    look;
    chk({24'h0, keypad_pin_mode}, 32'h08);
    chk({31'h0, keypad_irq}, 32'h0);
    chk({31'h0, keypad_wake}, 32'h1);
    wr(KPLI_ADDR_CONTROL, 32'h1);
    look;
    chk({31'h0, keypad_irq}, 32'h1);
    rd(KPLI_ADDR_CONTROL, 32'h7);
    press(8'h00);
    chk({31'h0, keypad_irq}, 32'h1);
    chk({31'h0, keypad_wake}, 32'h0);
    wr(KPLI_ADDR_FLAGS, 32'h5a);
    rd(KPLI_ADDR_FLAGS, 32'h0);
    look;
    chk({31'h0, keypad_irq}, 32'h0);
  endtask

  // Released lines sit high, so high-level detection sees pin 7 at once.
  task t_high;
    wr(KPLI_ADDR_LEVEL_SELECT, 32'h80);
    settle;
    rd(KPLI_ADDR_LEVEL_SELECT, 32'h80);
    rd(KPLI_ADDR_FLAGS, 32'h80);
    look;
    chk({31'h0, keypad_irq}, 32'h0);
    wr(KPLI_ADDR_FLAGS, 32'hff);
    rd(KPLI_ADDR_FLAGS, 32'h80);
    wr(KPLI_ADDR_LEVEL_SELECT, 32'h0);
    wr(KPLI_ADDR_FLAGS, 32'h0);
    rd(KPLI_ADDR_FLAGS, 32'h0);
  endtask

  task t_event;
    rd(KPLI_ADDR_INT_STATUS, 32'h88);
    rd(KPLI_ADDR_INT_STATUS, 32'h0);
    press(8'h01);
    chk({31'h0, event_irq}, 32'h0);
    wr(KPLI_ADDR_INT_MASK, 32'h01);
    look;
    chk({31'h0, event_irq}, 32'h1);
    rd(KPLI_ADDR_INT_STATUS, 32'h01);
    look;
    chk({31'h0, event_irq}, 32'h0);
    press(8'h00);
  endtask

  // Configuration writes need byte lane 0; unmapped writes are refused.
  task t_strobe;
    @(posedge pclk);
    pstrb <= 4'he;
    wr(KPLI_ADDR_INPUT_ENABLE, 32'hff);
    rd(KPLI_ADDR_INPUT_ENABLE, 32'h08);
    wr(KPLI_ADDR_CONTROL, 32'h0);
    rd(KPLI_ADDR_CONTROL, 32'h1);
    @(posedge pclk);
    pstrb <= 4'hf;
    wr(12'h300, 32'hff);
    chk({31'h0, err}, 32'h1);
    rd(KPLI_ADDR_INPUT_ENABLE, 32'h08);
  endtask

  initial
  begin
    #20000;
    miscompares++;
    tally_and_finish;
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    pressed = 8'h00;
    miscompares = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_low;
    t_high;
    t_event;
    t_strobe;
    tally_and_finish;
  end
endmodule

// [dv/kpli_keys.sv]
`timescale 1ns/100ps
module kpli_keys
  import kpli_pkg::*;
(
  // Key presses from the bench.
  input  wire logic [KPLI_NUM_INPUTS-1:0] pressed,
  // Port A lines.
  output logic      [KPLI_NUM_INPUTS-1:0] port_a_pin
);
  // A key shorts its line to ground; a pull-up holds a released line high.
  assign port_a_pin = ~pressed;
endmodule

// [verilog/kpli_keypad.sv]
// Behaviour
// - Eight inputs, one shared interrupt request.
// - Global enable gates combined keypad interrupt.
// - Level select clear means low, set high.
// - Flag sets while input shows active level.
// - Flag bit n belongs to port pin n.
// - Flag requests interrupt only when enabled.
// - Any flag register write clears all flags except those of inputs still at their active level.
// - Disabled input stays an ordinary I/O pin.
// - Enabled active input raises wake request.
`timescale 1ns/100ps
module kpli_keypad
  import kpli_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = KPLI_NUM_INPUTS
)
(
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Keypad pins on port A.
  input  wire logic [NUM_INPUTS-1:0] port_a_pin,
  output logic      [NUM_INPUTS-1:0] keypad_pin_mode,
  // Interrupt and wake.
  output logic                       keypad_irq,
  output logic                       keypad_wake,
  output logic                       event_irq
);

  initial
  begin
    if (NUM_INPUTS < 1 || NUM_INPUTS > 8)
      $error("kpli_keypad: NUM_INPUTS must lie between 1 and 8");
  end

  logic [NUM_INPUTS-1:0] keypad_level_select_q;
  logic [NUM_INPUTS-1:0] keypad_input_enable_q;
  logic [NUM_INPUTS-1:0] keypad_flags_q;
  logic [NUM_INPUTS-1:0] keypad_flags_d;
  logic                  global_en_q;
  logic [NUM_INPUTS-1:0] int_status_q;
  logic [NUM_INPUTS-1:0] int_status_d;
  logic [NUM_INPUTS-1:0] int_mask_q;
  logic [NUM_INPUTS-1:0] keypad_in_sync;

  kpli_sync #(
    .WIDTH    (NUM_INPUTS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (port_a_pin),
    .sync_out (keypad_in_sync)
  );

  // Bus decode.
  wire access_phase = psel & penable;
  wire wr_en        = access_phase & pwrite;
  wire rd_en        = access_phase & ~pwrite;
  wire low_lane     = pstrb[0];
  wire hit_lsel     = (paddr == KPLI_ADDR_LEVEL_SELECT);
  wire hit_ien      = (paddr == KPLI_ADDR_INPUT_ENABLE);
  wire hit_flags    = (paddr == KPLI_ADDR_FLAGS);
  wire hit_ctrl     = (paddr == KPLI_ADDR_CONTROL);
  wire hit_ists     = (paddr == KPLI_ADDR_INT_STATUS);
  wire hit_imask    = (paddr == KPLI_ADDR_INT_MASK);
  wire hit_any      = hit_lsel | hit_ien | hit_flags | hit_ctrl | hit_ists | hit_imask;

  // Active level per input: XNOR of pin and level select.
  wire [NUM_INPUTS-1:0] active_level = ~(keypad_in_sync ^ keypad_level_select_q);
  // Flag bit n follows input n only; no cross-wiring between pins.
  wire [NUM_INPUTS-1:0] flag_set     = active_level;
  wire                  flags_wr     = wr_en & hit_flags;
  wire [NUM_INPUTS-1:0] flag_enabled = keypad_flags_q & keypad_input_enable_q;
  wire                  irq_raw      = global_en_q & (|flag_enabled);
  wire [NUM_INPUTS-1:0] wake_src     = active_level & keypad_input_enable_q;

  // A pin set during the clearing write wins over the clear.
  assign keypad_flags_d = (flags_wr ? '0 : keypad_flags_q) | flag_set;

  // Sticky event status: a new flag edge sets, a read of status clears.
  wire [NUM_INPUTS-1:0] new_flag  = flag_set & ~keypad_flags_q;
  wire                  ists_rd   = rd_en & hit_ists;
  assign int_status_d = (ists_rd ? '0 : int_status_q) | new_flag;

  // Read mux; unused upper bits read zero.
  wire [7:0] ctrl_rd = {5'h00, keypad_wake, keypad_irq, global_en_q};
  wire [31:0] rd_mux =
    hit_lsel  ? {24'h000000, 8'(keypad_level_select_q)} :
    hit_ien   ? {24'h000000, 8'(keypad_input_enable_q)} :
    hit_flags ? {24'h000000, 8'(keypad_flags_q)} :
    hit_ctrl  ? {24'h000000, ctrl_rd} :
    hit_ists  ? {24'h000000, 8'(int_status_q)} :
    hit_imask ? {24'h000000, 8'(int_mask_q)} :
                32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      keypad_level_select_q <= KPLI_RST_LEVEL_SELECT[NUM_INPUTS-1:0];
      keypad_input_enable_q <= KPLI_RST_INPUT_ENABLE[NUM_INPUTS-1:0];
      int_mask_q            <= KPLI_RST_INT_MASK[NUM_INPUTS-1:0];
      global_en_q           <= KPLI_RST_GLOBAL_EN;
    end
    else if (wr_en && low_lane)
    begin
      if (hit_lsel)
        keypad_level_select_q <= pwdata[NUM_INPUTS-1:0];
      if (hit_ien)
        keypad_input_enable_q <= pwdata[NUM_INPUTS-1:0];
      if (hit_imask)
        int_mask_q <= pwdata[NUM_INPUTS-1:0];
      if (hit_ctrl)
        global_en_q <= pwdata[KPLI_CTRL_GLOBAL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      keypad_flags_q <= KPLI_RST_FLAGS[NUM_INPUTS-1:0];
      int_status_q   <= KPLI_RST_INT_STATUS[NUM_INPUTS-1:0];
    end
    else
    begin
      keypad_flags_q <= keypad_flags_d;
      int_status_q   <= int_status_d;
    end
  end

  // Zero-wait slave; read data comes straight from the registers in the access phase.
  // A registered copy would miss a status bit cleared by the same read.
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~hit_any;
  assign prdata  = rd_mux;

  // Disabled inputs are left to the ordinary port logic.
  assign keypad_pin_mode = keypad_input_enable_q;
  assign keypad_irq      = irq_raw;
  // Combinational, but fed from the synchronised pins, so a new press needs pclk running.
  assign keypad_wake     = |wake_src;
  assign event_irq       = |(int_status_q & int_mask_q);

  // Assertions.
  logic [NUM_INPUTS-1:0] pin_d1_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_d1_q <= '1;
    else
      pin_d1_q <= port_a_pin;
  end

  sequence s_flag_write;
    wr_en && hit_flags;
  endsequence

  a_sync_two_stage: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> ##2 (keypad_in_sync == $past(port_a_pin, 2)))
    else $error("synchronizer is not two stages deep");

  a_level_low_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!keypad_level_select_q[0] && !keypad_in_sync[0]) |=> keypad_flags_q[0])
    else $error("low level on input 0 did not set its flag");

  a_level_high_set: assert property (@(posedge pclk) disable iff (!presetn)
    (keypad_level_select_q[0] && keypad_in_sync[0]) |=> keypad_flags_q[0])
    else $error("high level on input 0 did not set its flag");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (keypad_flags_q != '0 && !flags_wr) |=> ((keypad_flags_q & $past(keypad_flags_q))
      == $past(keypad_flags_q)))
    else $error("flag dropped without a clearing write");

  a_flag_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_write |=> (keypad_flags_q == $past(flag_set)))
    else $error("flag write did not clear all flags");

  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    ((keypad_flags_q & keypad_input_enable_q) == '0) |-> !keypad_irq)
    else $error("interrupt raised with no enabled flag");

  a_irq_global_off: assert property (@(posedge pclk) disable iff (!presetn)
    !global_en_q |-> !keypad_irq)
    else $error("interrupt raised while globally disabled");

  a_irq_equation: assert property (@(posedge pclk) disable iff (!presetn)
    (global_en_q && (keypad_flags_q & keypad_input_enable_q) != '0) |-> keypad_irq)
    else $error("enabled flag did not raise interrupt");

  a_wake_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(keypad_wake) |-> (keypad_input_enable_q != '0))
    else $error("wake raised by a disabled input");

  a_gpio_mode: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(keypad_input_enable_q[0]) |-> !keypad_pin_mode[0])
    else $error("disabled input still in keypad mode");

  sequence s_lsel_write;
    wr_en && low_lane && hit_lsel;
  endsequence

  sequence s_ien_write;
    wr_en && low_lane && hit_ien;
  endsequence

  sequence s_ctrl_write;
    wr_en && low_lane && hit_ctrl;
  endsequence

  sequence s_mask_write;
    wr_en && low_lane && hit_imask;
  endsequence

  sequence s_status_read;
    rd_en && hit_ists;
  endsequence

  // The synchronised value lags the delayed pin copy by one more stage.
  a_sync_follow: assert property (@(posedge pclk) disable iff (!presetn)
    keypad_in_sync == $past(pin_d1_q))
    else $error("synchronizer output does not follow the pins");

  // Every input at its active level has its flag set on the next edge.
  a_flag_set_any: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_set != '0) |=> ((keypad_flags_q & $past(flag_set)) == $past(flag_set)))
    else $error("active input did not set its flag");

  // The top input drives the top flag bit.
  a_flag_top_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (keypad_in_sync[NUM_INPUTS-1] == keypad_level_select_q[NUM_INPUTS-1])
      |=> keypad_flags_q[NUM_INPUTS-1])
    else $error("top input did not set the top flag");

  // A flag never rises without its own input at the active level.
  a_flag_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((keypad_flags_q & ~$past(keypad_flags_q) & ~$past(flag_set)) == '0))
    else $error("flag rose without an active input");

  // After a clearing write only inputs still active keep their flag.
  a_clear_keeps_active: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_write |=> ((keypad_flags_q & ~$past(flag_set)) == '0))
    else $error("flag survived a clearing write");

  // The request needs at least one enabled flag.
  a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
    keypad_irq |-> ((keypad_flags_q & keypad_input_enable_q) != '0))
    else $error("interrupt without an enabled flag");

  // With every input left to the port logic, neither keypad request nor wake is raised.
  a_gpio_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (keypad_input_enable_q == '0) |-> (!keypad_irq && !keypad_wake))
    else $error("disabled inputs raised a request");

  // An enabled input at its active level must request wake.
  a_wake_active: assert property (@(posedge pclk) disable iff (!presetn)
    ((active_level & keypad_input_enable_q) != '0) |-> keypad_wake)
    else $error("enabled active input did not request wake");

  // Wake is never requested with all inputs disabled.
  a_wake_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    keypad_wake |-> (keypad_input_enable_q != '0))
    else $error("wake requested with no input enabled");

  // A level select write lands on the access edge.
  a_lsel_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_lsel_write |=> (keypad_level_select_q == $past(pwdata[NUM_INPUTS-1:0])))
    else $error("level select write did not land");

  // An input enable write lands on the access edge.
  a_ien_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ien_write |=> (keypad_input_enable_q == $past(pwdata[NUM_INPUTS-1:0])))
    else $error("input enable write did not land");

  // The global enable follows its control bit.
  a_gen_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> (global_en_q == $past(pwdata[KPLI_CTRL_GLOBAL_EN_BIT])))
    else $error("global enable write did not land");

  // An event mask write lands on the access edge.
  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_mask_write |=> (int_mask_q == $past(pwdata[NUM_INPUTS-1:0])))
    else $error("event mask write did not land");

  // Without the low byte lane no configuration register may change.
  a_strobe_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !low_lane) |=> ($stable(keypad_input_enable_q) && $stable(keypad_level_select_q)
      && $stable(global_en_q) && $stable(int_mask_q)))
    else $error("write without low lane changed a register");

  // A write to an unmapped address changes nothing.
  a_unmapped_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !hit_any) |=> ($stable(keypad_input_enable_q) && $stable(keypad_level_select_q)
      && $stable(global_en_q) && $stable(int_mask_q)))
    else $error("unmapped write changed a register");

  // A new flag always reaches the event status, even during its read.
  a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    (new_flag != '0) |=> ((int_status_q & $past(new_flag)) == $past(new_flag)))
    else $error("new flag did not set event status");

  // A status read leaves only bits set on that same edge.
  a_status_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read |=> ((int_status_q & ~$past(new_flag)) == '0))
    else $error("status read did not clear event status");

  // Status bits hold until their register is read.
  a_status_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !ists_rd |=> ((int_status_q & $past(int_status_q)) == $past(int_status_q)))
    else $error("event status dropped without a read");

  // Masked status never raises the event line.
  a_event_masked: assert property (@(posedge pclk) disable iff (!presetn)
    ((int_status_q & int_mask_q) == '0) |-> !event_irq)
    else $error("event line high with no unmasked status");

  // Unmasked status always raises the event line.
  a_event_raised: assert property (@(posedge pclk) disable iff (!presetn)
    ((int_status_q & int_mask_q) != '0) |-> event_irq)
    else $error("unmasked status did not raise event line");

  // The error response marks exactly the unmapped accesses.
  a_slverr_decode: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase |-> (pslverr == !hit_any))
    else $error("slave error does not match the decode");

  // Only the low byte of any register carries data.
  a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en |-> (prdata[31:8] == 24'h000000))
    else $error("upper read bits not zero");

  // Input 0 alone, enabled and flagged, raises the shared request.
  a_irq_low_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (global_en_q && keypad_flags_q[0] && keypad_input_enable_q[0]) |-> keypad_irq)
    else $error("input 0 did not raise the shared request");

  // The control read shows the live request level.
  a_ctrl_irq_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && hit_ctrl) |-> (prdata[KPLI_CTRL_IRQ_BIT] == keypad_irq))
    else $error("control read does not show the request");

endmodule

// [verilog/kpli_pkg.sv]
package kpli_pkg;

  localparam int unsigned KPLI_NUM_INPUTS = 8;
  localparam int unsigned KPLI_SYNC_STAGES = 2;

  // Printed offsets are not multiples of four: they are word indices.
  localparam logic [7:0] KPLI_IDX_LEVEL_SELECT = 8'h8d;
  localparam logic [7:0] KPLI_IDX_INPUT_ENABLE = 8'h8e;
  localparam logic [7:0] KPLI_IDX_FLAGS        = 8'h8f;
  localparam logic [7:0] KPLI_IDX_CONTROL      = 8'h90;
  localparam logic [7:0] KPLI_IDX_INT_STATUS   = 8'h91;
  localparam logic [7:0] KPLI_IDX_INT_MASK     = 8'h92;

  localparam logic [11:0] KPLI_ADDR_LEVEL_SELECT = {2'h0, KPLI_IDX_LEVEL_SELECT, 2'h0};
  localparam logic [11:0] KPLI_ADDR_INPUT_ENABLE = {2'h0, KPLI_IDX_INPUT_ENABLE, 2'h0};
  localparam logic [11:0] KPLI_ADDR_FLAGS        = {2'h0, KPLI_IDX_FLAGS, 2'h0};
  localparam logic [11:0] KPLI_ADDR_CONTROL      = {2'h0, KPLI_IDX_CONTROL, 2'h0};
  localparam logic [11:0] KPLI_ADDR_INT_STATUS   = {2'h0, KPLI_IDX_INT_STATUS, 2'h0};
  localparam logic [11:0] KPLI_ADDR_INT_MASK     = {2'h0, KPLI_IDX_INT_MASK, 2'h0};

  localparam logic [7:0] KPLI_RST_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] KPLI_RST_INPUT_ENABLE = 8'h00;
  localparam logic [7:0] KPLI_RST_FLAGS        = 8'h00;
  localparam logic [7:0] KPLI_RST_INT_STATUS   = 8'h00;
  localparam logic [7:0] KPLI_RST_INT_MASK     = 8'h00;
  localparam logic       KPLI_RST_GLOBAL_EN    = 1'b0;

  // Control register field positions.
  localparam int unsigned KPLI_CTRL_GLOBAL_EN_BIT = 0;
  localparam int unsigned KPLI_CTRL_IRQ_BIT       = 1;
  localparam int unsigned KPLI_CTRL_WAKE_BIT      = 2;

endpackage

// [verilog/kpli_sync.sv]
`timescale 1ns/100ps
module kpli_sync
  import kpli_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  initial
  begin
    if (WIDTH < 1)
      $error("kpli_sync: WIDTH must be at least one");
  end

  // The first stage feeds only the second; nothing else may look at it.
  // Both stages reset high, the idle level of a pulled-up key line.
  // A low reset value would show every line as pressed for two cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1_q <= '1;
      stage2_q <= '1;
    end
    else
    begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule
